// *** usr_pkg.sv ***
// Purpose: shared constants for the session request sequencer ends
// Assumes: 40 MHz ref_clk, comparator levels arrive synchronous
// Notes:   times in their own units, cycle counts derived here
//
// Summary of operation
// - request needs vbus low, se0 two ms
// - b-device performs both pulsing methods
// - pull-up held five to ten ms
// - data-line pulse only on d+
// - a-side flags request on d+ or d-
// - a-side data-pulse detection can be disabled
// - re-enable detection once data line low
// - vbus pulse time bounded by parameter
// - a-side flags request above session valid
// - vbus above b session valid means session
// - b pull-up within one second of valid, here timed from session entry, so up to one vbus pulse later
// - request activity finishes within 100 ms
// - vbus level ignored during vbus pulse
// - data-line pulse precedes vbus pulse
// - wait five seconds before failure report
// - a-side answers within five seconds
// - a-side answers with vbus then reset
// - request may repeat when conditions return
package usr_pkg;
  localparam int unsigned CLK_HZ                     = 40_000_000;
  localparam int unsigned LINE_IDLE_US               = 2_000;
  localparam int unsigned DATA_PULSE_US              = 7_000;
  localparam int unsigned VBUS_PULSE_US              = 20_000;
  localparam int unsigned REQUEST_INIT_US            = 100_000;
  localparam int unsigned CONNECT_US                 = 1_000_000;
  localparam int unsigned FAIL_WAIT_US               = 5_000_000;
  localparam int unsigned RESET_SIG_US               = 10_000;
  localparam int unsigned CYC_PER_US                 = CLK_HZ / 1_000_000;
  localparam int unsigned LINE_IDLE_CYC              = LINE_IDLE_US * CYC_PER_US;
  localparam int unsigned DATA_PULSE_CYC             = DATA_PULSE_US * CYC_PER_US;
  localparam int unsigned VBUS_PULSE_CYC             = VBUS_PULSE_US * CYC_PER_US;
  localparam int unsigned REQUEST_INIT_CYC           = REQUEST_INIT_US * CYC_PER_US;
  localparam int unsigned CONNECT_CYC                = CONNECT_US * CYC_PER_US;
  localparam int unsigned FAIL_WAIT_CYC              = FAIL_WAIT_US * CYC_PER_US;
  localparam int unsigned RESET_SIG_CYC              = RESET_SIG_US * CYC_PER_US;
  localparam int unsigned TIMER_W                    = 28;
endpackage

// *** usr_link_if.sv ***
// Purpose: link between b-side requester and a-side responder
// Assumes: one ref_clk shared by both ends
// Notes:   pull-ups and vbus drive are plain levels here
`timescale 1ns/100ps
`default_nettype none
interface usr_link_if;
  logic dp_pullup;
  logic dm_pullup;
  logic b_vbus_drive;
  logic a_vbus_drive;
  logic bus_reset;
  logic vbus_b_session_valid;
  logic vbus_b_session_end;
  logic vbus_a_session_valid;
  logic line_dp_high;
  logic line_dm_high;
  modport b_end (
    output dp_pullup, dm_pullup, b_vbus_drive,
    input  vbus_b_session_valid, vbus_b_session_end, line_dp_high, line_dm_high, bus_reset
  );
  modport a_end (
    output a_vbus_drive, bus_reset,
    input  vbus_a_session_valid, line_dp_high, line_dm_high
  );
endinterface
`default_nettype wire

// *** usr_b_requester.sv ***
// Purpose: b-side session request sequencer
// Assumes: comparator inputs synchronous to ref_clk
// Notes:   long counts except the request-init cap are parameters so simulation can shorten them
`timescale 1ns/100ps
`default_nettype none
module usr_b_requester #(
  parameter int unsigned LINE_IDLE_CYC  = usr_pkg::LINE_IDLE_CYC,
  parameter int unsigned DATA_PULSE_CYC = usr_pkg::DATA_PULSE_CYC,
  parameter int unsigned VBUS_PULSE_CYC = usr_pkg::VBUS_PULSE_CYC,
  parameter int unsigned CONNECT_CYC    = usr_pkg::CONNECT_CYC,
  parameter int unsigned FAIL_WAIT_CYC  = usr_pkg::FAIL_WAIT_CYC
) (
  input  wire logic  ref_clk,
  input  wire logic  sys_rst,
  input  wire logic  request_start,
  input  wire logic  connect_enable,
  output logic       request_busy,
  output logic       request_failed,
  output logic       session_started,
  output logic       session_active,
  usr_link_if.b_end  link
);
  localparam int W = usr_pkg::TIMER_W;

  typedef enum logic [2:0] {
    USR_IDLE, USR_DATA_PULSE, USR_VBUS_PULSE, USR_WAIT_RESP, USR_SESSION
  } usr_b_state_t;

  usr_b_state_t state;
  logic [W-1:0] idle_cnt;
  logic [W-1:0] timer;
  logic         conditions_met;
  logic         pending;
  logic [W-1:0] blind_cnt;
  logic         blind_over;

  // ------------------------------------------------------------
  // initial-condition watch
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !link.vbus_b_session_end || link.line_dp_high || link.line_dm_high) begin
      idle_cnt <= '0;
    end else if (idle_cnt < W'(LINE_IDLE_CYC)) begin
      idle_cnt <= idle_cnt + 1'b1;
    end
  end
  assign conditions_met = (idle_cnt >= W'(LINE_IDLE_CYC));

  // ------------------------------------------------------------
  // request latch
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pending <= 1'b0;
    end else if (request_start) begin
      pending <= 1'b1; // set wins over consume
    end else if (state == USR_IDLE && conditions_met) begin
      pending <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= USR_IDLE;
      timer <= '0;
    end else begin
      case (state)
        USR_IDLE: begin
          timer <= '0;
          // a live session skips the request
          if (link.vbus_b_session_valid) begin
            state <= USR_SESSION;
          end else if (pending && conditions_met) begin
            state <= USR_DATA_PULSE;
          end
        end
        USR_DATA_PULSE: begin
          timer <= timer + 1'b1;
          // vbus still watched here, a quick answer ends the pulse
          if (link.vbus_b_session_valid) begin
            state <= USR_SESSION;
            timer <= '0;
          end else if (timer == W'(DATA_PULSE_CYC - 1)) begin
            state <= USR_VBUS_PULSE;
            timer <= '0;
          end
        end
        USR_VBUS_PULSE: begin
          timer <= timer + 1'b1;
          if (timer == W'(VBUS_PULSE_CYC - 1) || blind_over) begin
            state <= USR_WAIT_RESP;
            timer <= '0;
          end
        end
        USR_WAIT_RESP: begin
          // failure only after the full response wait
          timer <= timer + 1'b1;
          if (link.vbus_b_session_valid) begin
            state <= USR_SESSION;
            timer <= '0;
          end else if (timer == W'(FAIL_WAIT_CYC - 1)) begin
            state <= USR_IDLE;
          end
        end
        USR_SESSION: begin
          // connect timer saturates at its bound
          if (timer < W'(CONNECT_CYC)) begin
            timer <= timer + 1'b1;
          end
          if (!link.vbus_b_session_valid) begin
            state <= USR_IDLE;
          end
        end
        default: begin
          state <= USR_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // unmonitored-time guard
  // ------------------------------------------------------------
  // vbus is blind only while pulsing, so cap that span
  always_ff @(posedge ref_clk) begin
    if (sys_rst || state != USR_VBUS_PULSE) begin
      blind_cnt <= '0;
    end else if (!blind_over) begin
      blind_cnt <= blind_cnt + 1'b1;
    end
  end
  assign blind_over = (blind_cnt >= W'(usr_pkg::REQUEST_INIT_CYC - 1));

  // ------------------------------------------------------------
  // pin drive, all registered
  // ------------------------------------------------------------
  // connect well inside the one-second bound, forced before its end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      link.dp_pullup <= 1'b0;
    end else begin
      link.dp_pullup <= (state == USR_DATA_PULSE && !(timer == W'(DATA_PULSE_CYC - 1))) ||
                        (state == USR_SESSION &&
                         (connect_enable || timer >= W'(CONNECT_CYC - 2)) &&
                         link.vbus_b_session_valid);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      link.dm_pullup <= 1'b0;
    end else begin
      link.dm_pullup <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      link.b_vbus_drive <= 1'b0;
    end else begin
      link.b_vbus_drive <= (state == USR_DATA_PULSE && timer == W'(DATA_PULSE_CYC - 1)) ||
                           (state == USR_VBUS_PULSE && timer != W'(VBUS_PULSE_CYC - 1) && !blind_over);
    end
  end

  // ------------------------------------------------------------
  // status toward software
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      request_busy <= 1'b0;
    end else begin
      request_busy <= pending || (state inside {USR_DATA_PULSE, USR_VBUS_PULSE, USR_WAIT_RESP});
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      session_active <= 1'b0;
    end else begin
      session_active <= link.vbus_b_session_valid && state != USR_VBUS_PULSE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      request_failed <= 1'b0;
    end else if (state == USR_WAIT_RESP && !link.vbus_b_session_valid && timer == W'(FAIL_WAIT_CYC - 1)) begin
      request_failed <= 1'b1;
    end else if (request_start) begin
      request_failed <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      session_started <= 1'b0;
    end else if (state != USR_SESSION && state != USR_VBUS_PULSE && link.vbus_b_session_valid) begin
      session_started <= 1'b1;
    end else if (request_start) begin
      session_started <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** usr_a_responder.sv ***
// Purpose: a-side session request detector and responder
// Assumes: line and vbus levels synchronous to ref_clk
// Notes:   response is vbus on, then a timed bus reset
`timescale 1ns/100ps
`default_nettype none
module usr_a_responder #(
  parameter int unsigned RESET_SIG_CYC = usr_pkg::RESET_SIG_CYC
) (
  input  wire logic  ref_clk,
  input  wire logic  sys_rst,
  input  wire logic  data_detect_enable,
  input  wire logic  vbus_detect_enable,
  input  wire logic  vbus_off,
  output logic       request_seen,
  output logic       session_on,
  usr_link_if.a_end  link
);
  localparam int W = usr_pkg::TIMER_W;

  logic [W-1:0] rst_cnt;
  logic         line_high;
  logic         data_inhibit;

  assign line_high = link.line_dp_high || link.line_dm_high;

  // ------------------------------------------------------------
  // offending-device inhibit
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      data_inhibit <= 1'b0;
    end else if (!data_detect_enable) begin
      data_inhibit <= 1'b1;
    end else if (!line_high && !link.a_vbus_drive) begin
      data_inhibit <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // detection and response
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      request_seen      <= 1'b0;
      session_on        <= 1'b0;
      link.a_vbus_drive <= 1'b0;
      link.bus_reset    <= 1'b0;
      rst_cnt           <= '0;
    end else begin
      request_seen <= 1'b0;
      if (link.a_vbus_drive) begin
        if (vbus_off) begin
          link.a_vbus_drive <= 1'b0;
          rst_cnt           <= '0;
          link.bus_reset    <= 1'b0;
          session_on        <= 1'b0;
        end else if (link.vbus_a_session_valid && !session_on) begin
          link.bus_reset <= 1'b1;
          rst_cnt        <= rst_cnt + 1'b1;
          if (rst_cnt == W'(RESET_SIG_CYC - 1)) begin
            link.bus_reset <= 1'b0;
            session_on     <= 1'b1;
            rst_cnt        <= '0;
          end
        end
      end else if (!vbus_off &&
                   ((line_high && data_detect_enable && !data_inhibit) ||
                    (link.vbus_a_session_valid && vbus_detect_enable))) begin
        request_seen      <= 1'b1;
        link.a_vbus_drive <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** usr_link_sva.sv ***
// Purpose: protocol checks on the session request link
// Assumes: both ends share ref_clk, sync reset high
// Notes:   counts follow the shortened parameters of the bench
`timescale 1ns/100ps
`default_nettype none
module usr_link_sva #(
  parameter int LINE_IDLE_CYC  = 20,
  parameter int DATA_PULSE_CYC = 50,
  parameter int VBUS_PULSE_CYC = 40,
  parameter int CONNECT_CYC    = 200,
  parameter int RESET_SIG_CYC  = 10
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic dp_pullup,
  input wire logic dm_pullup,
  input wire logic b_vbus_drive,
  input wire logic a_vbus_drive,
  input wire logic bus_reset,
  input wire logic vbus_b_session_valid,
  input wire logic vbus_b_session_end,
  input wire logic vbus_a_session_valid,
  input wire logic line_dp_high,
  input wire logic line_dm_high
);
  localparam int CONN_LIM = CONNECT_CYC + VBUS_PULSE_CYC + 2;
  logic [15:0] dp_run, last_len, vb_run, rst_run, idle_run;
  logic        line_idle;
  assign line_idle = vbus_b_session_end && !line_dp_high && !line_dm_high;
  // ----------------------------------------
  // run length counters
  // ----------------------------------------
  always_ff @(posedge ref_clk) dp_run <= (sys_rst || !dp_pullup) ? 16'h0 : dp_run + 16'h1;
  always_ff @(posedge ref_clk) last_len <= sys_rst ? 16'h0 : (dp_run != 16'h0 ? dp_run : last_len);
  always_ff @(posedge ref_clk) vb_run <= (sys_rst || !b_vbus_drive) ? 16'h0 : vb_run + 16'h1;
  always_ff @(posedge ref_clk) rst_run <= (sys_rst || !bus_reset) ? 16'h0 : rst_run + 16'h1;
  always_ff @(posedge ref_clk) idle_run <= (sys_rst || !line_idle) ? 16'h0 :
                                           (idle_run == 16'hffff ? idle_run : idle_run + 16'h1);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_dm_never; !dm_pullup; endproperty
  a_dm_never: assert property (p_dm_never) else $error("d- pull-up driven");
  property p_idle; $rose(dp_pullup) && !vbus_b_session_valid |-> idle_run >= LINE_IDLE_CYC; endproperty
  a_idle: assert property (p_idle) else $error("pulse without idle line");
  property p_order; $rose(b_vbus_drive) |-> !dp_pullup && ($past(dp_pullup) || $past(dp_pullup, 2)); endproperty
  a_order: assert property (p_order) else $error("vbus pulse not after data pulse");
  property p_data_len;
    $rose(b_vbus_drive) |-> (dp_run != 16'h0 ? dp_run : last_len) inside {[DATA_PULSE_CYC - 1:DATA_PULSE_CYC]};
  endproperty
  a_data_len: assert property (p_data_len) else $error("data pulse length wrong");
  property p_vbus_len; $fell(b_vbus_drive) |-> vb_run == VBUS_PULSE_CYC; endproperty
  a_vbus_len: assert property (p_vbus_len) else $error("vbus pulse length wrong");
  property p_quiet; b_vbus_drive |-> !dp_pullup && !dm_pullup; endproperty
  a_quiet: assert property (p_quiet) else $error("pull-up during vbus pulse");
  property p_connect; $rose(vbus_b_session_valid) |-> ##[1:CONN_LIM] (dp_pullup || !vbus_b_session_valid); endproperty
  a_connect: assert property (p_connect) else $error("no pull-up after session valid");
  property p_reset_cause; $rose(bus_reset) |-> a_vbus_drive && vbus_a_session_valid; endproperty
  a_reset_cause: assert property (p_reset_cause) else $error("bus reset without vbus");
  property p_reset_len; $fell(bus_reset) |-> rst_run == RESET_SIG_CYC - 1; endproperty
  a_reset_len: assert property (p_reset_len) else $error("bus reset length wrong");
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Purpose: bench joining the b requester and the a responder
// Assumes: vbus and data lines modelled as logic levels
// Notes:   expected events queued by the driver, checked by a monitor
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  localparam int IDLE_C = 20, DPULSE_C = 50, VPULSE_C = 40, CONN_C = 200, FAIL_C = 500, RST_C = 10;
  logic       ref_clk, sys_rst, request_start, connect_enable;
  logic       data_detect_enable, vbus_detect_enable, vbus_off;
  logic       small_load, extra_dp, extra_dm;
  logic       request_busy, request_failed, session_started, session_active, request_seen, session_on;
  logic [3:0] prev_ev, rise_ev;
  logic [2:0] exp_q[$];
  int         err_total, num_checks, cyc, seed;
  usr_link_if usr_link_if_i ();
  usr_b_requester #(.LINE_IDLE_CYC(IDLE_C), .DATA_PULSE_CYC(DPULSE_C), .VBUS_PULSE_CYC(VPULSE_C),
    .CONNECT_CYC(CONN_C), .FAIL_WAIT_CYC(FAIL_C)) usr_b_requester_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .request_start(request_start), .connect_enable(connect_enable), .request_busy(request_busy),
    .request_failed(request_failed), .session_started(session_started), .session_active(session_active),
    .link(usr_link_if_i.b_end));
  usr_a_responder #(.RESET_SIG_CYC(RST_C)) usr_a_responder_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .data_detect_enable(data_detect_enable), .vbus_detect_enable(vbus_detect_enable), .vbus_off(vbus_off),
    .request_seen(request_seen), .session_on(session_on), .link(usr_link_if_i.a_end));
  usr_link_sva #(.LINE_IDLE_CYC(IDLE_C), .DATA_PULSE_CYC(DPULSE_C), .VBUS_PULSE_CYC(VPULSE_C),
    .CONNECT_CYC(CONN_C), .RESET_SIG_CYC(RST_C)) usr_link_sva_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .dp_pullup(usr_link_if_i.dp_pullup), .dm_pullup(usr_link_if_i.dm_pullup),
    .b_vbus_drive(usr_link_if_i.b_vbus_drive), .a_vbus_drive(usr_link_if_i.a_vbus_drive),
    .bus_reset(usr_link_if_i.bus_reset), .vbus_b_session_valid(usr_link_if_i.vbus_b_session_valid),
    .vbus_b_session_end(usr_link_if_i.vbus_b_session_end), .vbus_a_session_valid(usr_link_if_i.vbus_a_session_valid),
    .line_dp_high(usr_link_if_i.line_dp_high), .line_dm_high(usr_link_if_i.line_dm_high));
  // ----------------------------------------
  // cable model: small load lets the b pulse reach session valid
  // ----------------------------------------
  assign usr_link_if_i.line_dp_high = usr_link_if_i.dp_pullup | extra_dp;
  assign usr_link_if_i.line_dm_high = usr_link_if_i.dm_pullup | extra_dm;
  assign usr_link_if_i.vbus_a_session_valid = usr_link_if_i.a_vbus_drive | (usr_link_if_i.b_vbus_drive & small_load);
  assign usr_link_if_i.vbus_b_session_valid = usr_link_if_i.vbus_a_session_valid;
  assign usr_link_if_i.vbus_b_session_end = ~(usr_link_if_i.a_vbus_drive | usr_link_if_i.b_vbus_drive);
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic conclude();
    if (err_total == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic take(input logic [2:0] got);
    logic [2:0] exp;
    exp = (exp_q.size() != 0) ? exp_q.pop_front() : 3'h0;
    `CHK(got, exp)
  endtask
  task automatic ask();
    @(posedge ref_clk);
    #1 request_start = 1'b1;
    connect_enable = 1'($random(seed));
    @(posedge ref_clk);
    #1 request_start = 1'b0;
  endtask
  task automatic wait_q(input int lim);
    for (int i = 0; i < lim && exp_q.size() != 0; i++) @(posedge ref_clk);
    #1;
    if (exp_q.size() != 0) err_total++;
  endtask
  task automatic drop();
    vbus_off = 1'b1;
    repeat (40) @(posedge ref_clk);
    #1 vbus_off = 1'b0;
  endtask
  // ----------------------------------------
  // event monitor and time limit
  // ----------------------------------------
  always @(posedge ref_clk) begin
    rise_ev = {session_on, request_failed, session_started, request_seen} & ~prev_ev;
    prev_ev = {session_on, request_failed, session_started, request_seen};
    for (int i = 0; i < 4; i++) if (rise_ev[i] === 1'b1) take(3'(i + 1));
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end
  initial begin
    seed = 4368; err_total = 0; num_checks = 0; cyc = 0; prev_ev = 4'h0;
    sys_rst = 1'b1; request_start = 1'b0; connect_enable = 1'b0; vbus_off = 1'b0;
    data_detect_enable = 1'b1; vbus_detect_enable = 1'b0; small_load = 1'b0; extra_dp = 1'b0; extra_dm = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    // data-line path: seen, session, reset done
    exp_q = '{3'h1, 3'h2, 3'h4};
    ask();
    wait_q(3000);
    `CHK(session_active, 1'b1)
    repeat (CONN_C) @(posedge ref_clk);
    #1;
    `CHK(usr_link_if_i.dp_pullup, 1'b1)
    drop();
    // offending pull-up with data detect off, then vbus path
    data_detect_enable = 1'b0; vbus_detect_enable = 1'b1; small_load = 1'b1; extra_dp = 1'b1;
    ask();
    repeat (60) @(posedge ref_clk);
    #1;
    `CHK(request_busy, 1'b1)
    // vbus answer comes while the b side still ignores vbus
    exp_q = '{3'h1, 3'h4, 3'h2};
    extra_dp = 1'b0;
    wait_q(3000);
    drop();
    // no responder: own pulse masked, failure after the wait
    vbus_detect_enable = 1'b0;
    exp_q = '{3'h3};
    ask();
    wait_q(3000);
    `CHK(request_busy, 1'b0)
    // d- goes high at the a side
    data_detect_enable = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    exp_q = '{3'h1, 3'h2, 3'h4};
    extra_dm = 1'b1;
    repeat (1 + ($unsigned($random(seed)) % 8)) @(posedge ref_clk);
    #1 extra_dm = 1'b0;
    wait_q(3000);
    drop();
    `CHK(32'(exp_q.size()), 32'h0)
    conclude();
  end
endmodule
`default_nettype wire
